// ---- design/oce_top.sv ----
// option byte decode, reset stretch, boot entry and register slave
`timescale 1ns/10ps
module oce_top
#(
    parameter logic [15:0] NORMAL_VEC_ADDR = 16'hfffe,
    parameter logic [15:0] BOOT_VECTOR = 16'h0000
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] nv_option_byte,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    input wire logic irq_hv_pin,
    input wire logic mode_select_pin,
    input wire logic capture_pin_one,
    input wire logic capture_pin_two,
    input wire logic [7:0] portb_pin,
    input wire logic [7:0] portb_dir,
    input wire logic [7:0] portc_dir,
    input wire logic cpu_wait,
    output logic wired_or_irq,
    output logic [7:0] portb_pulldown,
    output logic [7:0] portc_pulldown,
    output logic cpu_clk_en,
    output logic watchdog_en,
    output logic watchdog_run,
    output logic boot_mode,
    output logic [15:0] reset_vector_addr,
    output logic irq
);
    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic idx_hit(logic [31:0] a, logic [16:0] idx);
        return (a[18:2] == idx) && (a[31:19] == 13'h0000);
    endfunction

    function automatic logic [3:0] div_ratio(logic hi, logic lo);
        logic [3:0] r;
        r = oce_pkg::RATIO_10;
        if (hi && lo)
            r = oce_pkg::RATIO_2;
        else if (hi)
            r = oce_pkg::RATIO_4;
        else if (lo)
            r = oce_pkg::RATIO_8;
        return r;
    endfunction

    // ----------------------------------------------------------------
    // option byte and latched settings
    // ----------------------------------------------------------------
    logic [7:0] option_byte;
    logic settled;
    logic cfg_woi, cfg_div_hi, cfg_div_lo, cfg_watchdog_after_reset_en, cfg_watchdog_in_wait_en, cfg_portb_pulldown_en, cfg_portc_pulldown_en;

    // no reset term: storage is nonvolatile
    always_ff @(posedge sys_clk)
    begin
        option_byte <= nv_option_byte;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            settled <= 1'b0;
            cfg_woi <= 1'b0;
            cfg_div_hi <= 1'b0;
            cfg_div_lo <= 1'b0;
            cfg_watchdog_after_reset_en <= 1'b0;
            cfg_watchdog_in_wait_en <= 1'b0;
            cfg_portb_pulldown_en <= 1'b0;
            cfg_portc_pulldown_en <= 1'b0;
        end
        else if (!settled)
        begin
            settled <= 1'b1;
            cfg_woi <= option_byte[oce_pkg::BIT_WOI];
            cfg_div_hi <= option_byte[oce_pkg::BIT_DIV_HI];
            cfg_div_lo <= option_byte[oce_pkg::BIT_DIV_LO];
            cfg_watchdog_after_reset_en <= option_byte[oce_pkg::BIT_WATCHDOG_AFTER_RESET_EN];
            cfg_watchdog_in_wait_en <= option_byte[oce_pkg::BIT_WATCHDOG_IN_WAIT_EN];
            cfg_portb_pulldown_en <= option_byte[oce_pkg::BIT_PORTB_PULLDOWN_EN];
            cfg_portc_pulldown_en <= option_byte[oce_pkg::BIT_PORTC_PULLDOWN_EN];
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [12:0] pin_s1, pin_s2;
    logic rpin_prev;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_s1 <= 13'h0000;
            pin_s2 <= 13'h0000;
            rpin_prev <= 1'b0;
        end
        else
        begin
            pin_s1 <= {portb_pin, capture_pin_two, capture_pin_one, mode_select_pin,
                       irq_hv_pin, reset_pin_in};
            pin_s2 <= pin_s1;
            rpin_prev <= pin_s2[0];
        end
    end

    // equal sync delay on all pins keeps the entry levels aligned with the edge
    wire pin_rise = pin_s2[0] && !rpin_prev;
    wire boot_cond = (pin_s2[1] || pin_s2[2]) && pin_s2[3] && !pin_s2[4];
    wire [7:0] pb_s = pin_s2[12:5];

    // ----------------------------------------------------------------
    // reset stretch
    // ----------------------------------------------------------------
    logic [11:0] stretch_cnt;
    wire [11:0] stretch_target = option_byte[oce_pkg::BIT_RESET_STRETCH_SELECT] ?
        oce_pkg::STRETCH_SHORT : oce_pkg::STRETCH_LONG;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stretch_cnt <= 12'h000;
            reset_pin_oe_n <= 1'b0;
            reset_pin_out <= 1'b0;
        end
        else if (!reset_pin_oe_n)
        begin
            if (stretch_cnt == 12'(stretch_target - 12'h001))
                reset_pin_oe_n <= 1'b1;
            else
                stretch_cnt <= 12'(stretch_cnt + 12'h001);
        end
    end

    // ----------------------------------------------------------------
    // boot entry, vector, watchdog
    // ----------------------------------------------------------------
    logic boot_entry;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            boot_mode <= 1'b0;
            boot_entry <= 1'b0;
            watchdog_en <= 1'b0;
            reset_vector_addr <= NORMAL_VEC_ADDR;
        end
        else
        begin
            boot_entry <= pin_rise && boot_cond;
            if (pin_rise)
            begin
                boot_mode <= boot_cond;
                reset_vector_addr <= boot_cond ? oce_pkg::BOOT_VEC_ADDR : NORMAL_VEC_ADDR;
                watchdog_en <= cfg_watchdog_after_reset_en && !boot_cond;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            watchdog_run <= 1'b0;
        else
            watchdog_run <= watchdog_en && (!cpu_wait || cfg_watchdog_in_wait_en);
    end

    // ----------------------------------------------------------------
    // clock divide
    // ----------------------------------------------------------------
    logic [3:0] ratio;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ratio <= oce_pkg::RATIO_2;
        else if (boot_mode)
            ratio <= oce_pkg::RATIO_2;
        else
            ratio <= div_ratio(cfg_div_hi, cfg_div_lo);
    end

    oce_clk_div oce_clk_div_inst
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .ratio(ratio),
        .cpu_clk_en(cpu_clk_en)
    );

    // ----------------------------------------------------------------
    // wired-OR interrupt and pull-downs (same in both modes)
    // ----------------------------------------------------------------
    logic wor_runtime_en;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wired_or_irq <= 1'b0;
            portb_pulldown <= 8'h00;
            portc_pulldown <= 8'h00;
        end
        else
        begin
            // low level on an input pin requests
            wired_or_irq <= cfg_woi && wor_runtime_en && |(~portb_dir & ~pb_s);
            portb_pulldown <= cfg_portb_pulldown_en ? ~portb_dir : 8'h00;
            portc_pulldown <= cfg_portc_pulldown_en ? ~portc_dir : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [2:0] status, mask;
    wire take = hsel && hready && htrans[1];
    logic [31:0] next_rdata;

    always_comb
    begin
        next_rdata = 32'h00000000;
        if (idx_hit(haddr, oce_pkg::IDX_OPTION))
            next_rdata = {24'h000000, option_byte};
        else if (idx_hit(haddr, oce_pkg::IDX_MEMCTL))
            next_rdata = {24'h000000, wor_runtime_en, 7'h00};
        else if (idx_hit(haddr, oce_pkg::IDX_BVEC_HI))
            next_rdata = {24'h000000, BOOT_VECTOR[15:8]};
        else if (idx_hit(haddr, oce_pkg::IDX_BVEC_LO))
            next_rdata = {24'h000000, BOOT_VECTOR[7:0]};
        else if (idx_hit(haddr, oce_pkg::IDX_STATUS))
            next_rdata = {29'h00000000, status};
        else if (idx_hit(haddr, oce_pkg::IDX_MASK))
            next_rdata = {29'h00000000, mask};
        else if (idx_hit(haddr, oce_pkg::IDX_STATE))
            next_rdata = {22'h000000, ratio, watchdog_run, watchdog_en,
                          !reset_pin_oe_n, boot_mode, settled, wired_or_irq};
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h00000000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend <= take && hwrite;
            if (take)
                wr_addr <= haddr;
            if (take && !hwrite)
                hrdata <= next_rdata;
        end
    end

    wire wr_memctl = wr_pend && idx_hit(wr_addr, oce_pkg::IDX_MEMCTL);
    wire wr_status = wr_pend && idx_hit(wr_addr, oce_pkg::IDX_STATUS);
    wire wr_mask = wr_pend && idx_hit(wr_addr, oce_pkg::IDX_MASK);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            wor_runtime_en <= 1'b0;
        else if (!cfg_woi)
            wor_runtime_en <= 1'b0;
        else if (wr_memctl)
            wor_runtime_en <= hwdata[oce_pkg::BIT_WIRED_OR_IRQ_RUNTIME_EN];
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    logic wor_prev, oe_prev;
    wire [2:0] events = {reset_pin_oe_n && !oe_prev, boot_entry, wired_or_irq && !wor_prev};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wor_prev <= 1'b0;
            oe_prev <= 1'b0;
            status <= oce_pkg::STATUS_RST;
            mask <= oce_pkg::MASK_RST;
            irq <= 1'b0;
        end
        else
        begin
            wor_prev <= wired_or_irq;
            oe_prev <= reset_pin_oe_n;
            // set wins over a write-one clear
            status <= (status & ~(wr_status ? hwdata[2:0] : 3'h0)) | events;
            if (wr_mask)
                mask <= hwdata[2:0];
            irq <= |(status & mask);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic [12:0] chk_low;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            chk_low <= 13'h0000;
        else if (!reset_pin_oe_n)
            chk_low <= 13'(chk_low + 13'h0001);
    end

    sequence pin_release_s;
        pin_rise ##0 settled;
    endsequence

    sequence boot_seen_s;
        pin_release_s ##0 boot_cond;
    endsequence

    wor_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        wired_or_irq |-> $past(cfg_woi) && $past(wor_runtime_en))
        else $error("wired-or irq without both enables");
    wor_source_a: assert property (@(posedge sys_clk) disable iff (rst)
        wired_or_irq |-> $past(|(~portb_dir & ~pb_s)))
        else $error("wired-or irq without an input pin request");
    div_ratio_a: assert property (@(posedge sys_clk) disable iff (rst)
        (settled && $past(settled) && !$past(boot_mode)) |->
        ratio == div_ratio($past(cfg_div_hi), $past(cfg_div_lo)))
        else $error("divide ratio does not follow select bits");
    boot_div_a: assert property (@(posedge sys_clk) disable iff (rst)
        boot_seen_s |=> ##1 (ratio == oce_pkg::RATIO_2) [*4])
        else $error("bootstrap ratio not two");
    stretch_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(reset_pin_oe_n) |-> chk_low == 13'(stretch_target))
        else $error("reset stretch length wrong");
    wdog_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
        pin_release_s |=> watchdog_en == ($past(cfg_watchdog_after_reset_en) && !$past(boot_cond)))
        else $error("watchdog enable after reset wrong");
    wdog_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cpu_wait && !cfg_watchdog_in_wait_en) |=> !watchdog_run)
        else $error("watchdog runs in wait");
    pull_b_a: assert property (@(posedge sys_clk) disable iff (rst)
        portb_pulldown == ($past(cfg_portb_pulldown_en) ? ~$past(portb_dir) : 8'h00))
        else $error("port b pull-down wrong");
    pull_c_a: assert property (@(posedge sys_clk) disable iff (rst)
        $stable(portc_dir) && $past(cfg_portc_pulldown_en) |-> portc_pulldown == ~portc_dir)
        else $error("port c pull-down wrong");
    nv_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(settled) |-> option_byte == $past(nv_option_byte))
        else $error("option byte altered");
    boot_vec_a: assert property (@(posedge sys_clk) disable iff (rst)
        boot_entry |-> boot_mode && reset_vector_addr == oce_pkg::BOOT_VEC_ADDR)
        else $error("bootstrap vector not selected");
    wired_or_irq_runtime_en_force_a: assert property (@(posedge sys_clk) disable iff (rst)
        (settled && !cfg_woi) |=> !wor_runtime_en ##1 !wor_runtime_en)
        else $error("runtime enable not forced low");
endmodule

// ---- include/oce_pkg.sv ----
// constants for the option byte loader and boot entry detector
package oce_pkg;
    // --------------------------------------------------------------
    // register indices (byte address is four times the index)
    // --------------------------------------------------------------
    localparam logic [16:0] IDX_OPTION = 17'h07fde;
    localparam logic [16:0] IDX_MEMCTL = 17'h00007;
    localparam logic [16:0] IDX_BVEC_HI = 17'h07fee;
    localparam logic [16:0] IDX_BVEC_LO = 17'h07fef;
    localparam logic [16:0] IDX_STATUS = 17'h00010;
    localparam logic [16:0] IDX_MASK = 17'h00011;
    localparam logic [16:0] IDX_STATE = 17'h00012;
    // --------------------------------------------------------------
    // option byte fields and memctl runtime enable bit
    // --------------------------------------------------------------
    localparam int BIT_WOI = 7;
    localparam int BIT_DIV_HI = 6;
    localparam int BIT_DIV_LO = 5;
    localparam int BIT_RESET_STRETCH_SELECT = 4;
    localparam int BIT_WATCHDOG_AFTER_RESET_EN = 3;
    localparam int BIT_WATCHDOG_IN_WAIT_EN = 2;
    localparam int BIT_PORTB_PULLDOWN_EN = 1;
    localparam int BIT_PORTC_PULLDOWN_EN = 0;
    localparam int BIT_WIRED_OR_IRQ_RUNTIME_EN = 7;
    // --------------------------------------------------------------
    // status bits, reset values
    // --------------------------------------------------------------
    localparam int ST_WOR = 0;
    localparam int ST_BOOT = 1;
    localparam int ST_STRETCH = 2;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    // --------------------------------------------------------------
    // divide ratios, timing and boot vector address
    // --------------------------------------------------------------
    localparam logic [3:0] RATIO_2 = 4'h2;
    localparam logic [3:0] RATIO_4 = 4'h4;
    localparam logic [3:0] RATIO_8 = 4'h8;
    localparam logic [3:0] RATIO_10 = 4'ha;
    localparam int STRETCH_SHORT_CYC = 16;
    localparam int STRETCH_LONG_CYC = 4064;
    localparam logic [11:0] STRETCH_SHORT = 12'(STRETCH_SHORT_CYC);
    localparam logic [11:0] STRETCH_LONG = 12'(STRETCH_LONG_CYC);
    localparam logic [15:0] BOOT_VEC_ADDR = 16'h7fee;
endpackage

// ---- design/oce_clk_div.sv ----
// cpu clock enable divider
`timescale 1ns/10ps
module oce_clk_div
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] ratio,
    output logic cpu_clk_en
);
    logic [3:0] cnt;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cnt <= 4'h0;
            cpu_clk_en <= 1'b0;
        end
        else if (cnt >= 4'(ratio - 4'h1))
        begin
            cnt <= 4'h0;
            cpu_clk_en <= 1'b1;
        end
        else
        begin
            cnt <= 4'(cnt + 4'h1);
            cpu_clk_en <= 1'b0;
        end
    end
endmodule

// ---- dv/oce_pin_model.sv ----
// far-side model: reset pin wire and bootstrap entry pin levels
`timescale 1ns/10ps
module oce_pin_model
(
    input wire logic sys_clk,
    input wire logic [1:0] boot_src,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    output logic reset_pin_level,
    output logic irq_hv_pin,
    output logic mode_select_pin,
    output logic capture_pin_one,
    output logic capture_pin_two
);
    logic [2:0] hold_cnt;
    logic [3:0] entry;
    // pulled up once the device lets go
    assign reset_pin_level = reset_pin_oe_n ? 1'b1 : reset_pin_out;
    always_ff @(posedge sys_clk)
    begin
        if (!reset_pin_level)
            hold_cnt <= 3'h0;
        else if (hold_cnt != 3'h7)
            hold_cnt <= hold_cnt + 3'h1;
    end
    // src 1: high-voltage irq pin, src 2: mode pin, 0: normal start
    assign entry = {boot_src == 2'h1, boot_src == 2'h2, boot_src != 2'h0, boot_src == 2'h0};
    // held two cycles after the rise, one more than the single sampled cycle, then turned round
    assign {irq_hv_pin, mode_select_pin, capture_pin_one, capture_pin_two} =
        (hold_cnt < 3'h2) ? entry : ~entry;
endmodule

// ---- dv/oce_top_tb.sv ----
// self-checking bench for the option byte loader and boot entry
`timescale 1ns/10ps
module oce_top_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] nv_option_byte = 8'h10;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] boot_src = 2'h0;
    logic [7:0] portb_pin = 8'hff;
    logic [7:0] portb_dir = 8'h0;
    logic [7:0] portc_dir = 8'h0;
    logic cpu_wait = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, reset_pin_out, reset_pin_oe_n, reset_pin_level;
    logic irq_hv_pin, mode_select_pin, capture_pin_one, capture_pin_two;
    logic wired_or_irq, cpu_clk_en, watchdog_en, watchdog_run, boot_mode, irq;
    logic [7:0] portb_pulldown, portc_pulldown;
    logic [15:0] reset_vector_addr;
    int n_mismatch = 0;
    int checked = 0;

    always #50 sys_clk = ~sys_clk;

    oce_top #(.NORMAL_VEC_ADDR(16'hfffe), .BOOT_VECTOR(16'h5aa5)) oce_top_inst
    (
        .sys_clk(sys_clk), .rst(rst), .nv_option_byte(nv_option_byte), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .reset_pin_in(reset_pin_level), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_n(reset_pin_oe_n), .irq_hv_pin(irq_hv_pin),
        .mode_select_pin(mode_select_pin), .capture_pin_one(capture_pin_one),
        .capture_pin_two(capture_pin_two), .portb_pin(portb_pin), .portb_dir(portb_dir),
        .portc_dir(portc_dir), .cpu_wait(cpu_wait), .wired_or_irq(wired_or_irq),
        .portb_pulldown(portb_pulldown), .portc_pulldown(portc_pulldown),
        .cpu_clk_en(cpu_clk_en), .watchdog_en(watchdog_en), .watchdog_run(watchdog_run),
        .boot_mode(boot_mode), .reset_vector_addr(reset_vector_addr), .irq(irq)
    );
    oce_pin_model oce_pin_model_inst
    (
        .sys_clk(sys_clk), .boot_src(boot_src), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_n(reset_pin_oe_n), .reset_pin_level(reset_pin_level),
        .irq_hv_pin(irq_hv_pin), .mode_select_pin(mode_select_pin),
        .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two)
    );

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [16:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {13'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [16:0] idx, input logic [31:0] v);
        logic [31:0] d;
        bus(1'b1, idx, v, d);
    endtask
    task automatic rd_chk(input string name, input logic [16:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        check(name, d, exp);
    endtask
    task automatic do_reset(input logic [7:0] opt, input logic [1:0] src);
        int n;
        @(posedge sys_clk);
        nv_option_byte <= opt;
        boot_src <= src;
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        n = 0;
        @(negedge sys_clk);
        while (reset_pin_oe_n !== 1'b1 && n < 5000)
        begin
            n++;
            @(negedge sys_clk);
        end
        check("stretch", 32'(n), opt[4] ? 32'd16 : 32'd4064);
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic period_chk(input logic [31:0] exp);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (cpu_clk_en !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge sys_clk);
        end
        n = 0;
        do
        begin
            n++;
            @(negedge sys_clk);
        end while (cpu_clk_en !== 1'b1 && n < 20);
        check("ratio", 32'(n), exp);
    endtask
    task automatic pin(input logic [7:0] v);
        @(posedge sys_clk);
        portb_pin <= v;
        repeat (6) @(negedge sys_clk);
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_regs();
        do_reset(8'h96, 2'h0);
        rd_chk("option", oce_pkg::IDX_OPTION, 32'h96);
        wr(oce_pkg::IDX_OPTION, 32'h5a);
        rd_chk("option ro", oce_pkg::IDX_OPTION, 32'h96);
        rd_chk("unmapped", 17'h00020, 32'h0);
        check("resp", 32'({hresp, hreadyout, reset_pin_out}), 32'h2);
        check("vector", 32'(reset_vector_addr), 32'hfffe);
        check("no boot", 32'(boot_mode), 32'h0);
    endtask
    task automatic t_ratio();
        logic [7:0] sel [4] = '{8'h70, 8'h50, 8'h30, 8'h00};
        logic [31:0] exp [4] = '{32'd2, 32'd4, 32'd8, 32'd10};
        for (int i = 0; i < 4; i++)
        begin
            do_reset(sel[i], 2'h0);
            period_chk(exp[i]);
        end
    endtask
    task automatic t_boot();
        for (int s = 1; s < 3; s++)
        begin
            @(posedge sys_clk);
            portb_dir <= 8'h3c;
            do_reset(8'h1a, 2'(s));
            check("boot", 32'(boot_mode), 32'h1);
            check("boot vec", 32'(reset_vector_addr), 32'h7fee);
            check("boot wdog", 32'(watchdog_en), 32'h0);
            check("boot pd", 32'({portb_pulldown, portc_pulldown}), 32'hc300);
            period_chk(32'd2);
            rd_chk("bvec hi", oce_pkg::IDX_BVEC_HI, 32'h5a);
            rd_chk("bvec lo", oce_pkg::IDX_BVEC_LO, 32'ha5);
        end
    endtask
    task automatic t_wdog();
        logic [7:0] opt [3] = '{8'h18, 8'h1c, 8'h14};
        for (int i = 0; i < 3; i++)
        begin
            do_reset(opt[i], 2'h0);
            check("wdog en", 32'(watchdog_en), 32'(opt[i][3]));
            @(posedge sys_clk);
            cpu_wait <= 1'b1;
            repeat (3) @(negedge sys_clk);
            check("wdog wait", 32'(watchdog_run), 32'(opt[i][3] & opt[i][2]));
            @(posedge sys_clk);
            cpu_wait <= 1'b0;
            repeat (3) @(negedge sys_clk);
            check("wdog run", 32'(watchdog_run), 32'(opt[i][3]));
        end
    endtask
    task automatic t_pull();
        do_reset(8'h13, 2'h0);
        @(posedge sys_clk);
        portb_dir <= 8'h0f;
        portc_dir <= 8'h81;
        repeat (3) @(negedge sys_clk);
        check("pd b", 32'(portb_pulldown), 32'hf0);
        check("pd c", 32'(portc_pulldown), 32'h7e);
        do_reset(8'h10, 2'h0);
        check("pd b off", 32'(portb_pulldown), 32'h0);
        check("pd c off", 32'(portc_pulldown), 32'h0);
    endtask
    task automatic t_wor();
        do_reset(8'h90, 2'h0);
        @(posedge sys_clk);
        portb_dir <= 8'hf0;
        wr(oce_pkg::IDX_MEMCTL, 32'h80);
        rd_chk("memctl", oce_pkg::IDX_MEMCTL, 32'h80);
        wr(oce_pkg::IDX_STATUS, 32'h7);
        wr(oce_pkg::IDX_MASK, 32'h1);
        pin(8'h7f);
        check("wor out pin", 32'(wired_or_irq), 32'h0);
        pin(8'hfe);
        check("wor", 32'(wired_or_irq), 32'h1);
        check("irq", 32'(irq), 32'h1);
        pin(8'hff);
        wr(oce_pkg::IDX_STATUS, 32'h1);
        rd_chk("status clr", oce_pkg::IDX_STATUS, 32'h0);
        check("irq clr", 32'(irq), 32'h0);
        wr(oce_pkg::IDX_MASK, 32'h0);
        pin(8'hfe);
        rd_chk("status set", oce_pkg::IDX_STATUS, 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        pin(8'hff);
        wr(oce_pkg::IDX_MEMCTL, 32'h0);
        pin(8'hfe);
        check("wor rt off", 32'(wired_or_irq), 32'h0);
        wr(oce_pkg::IDX_MEMCTL, 32'h80);
        do_reset(8'h90, 2'h0);
        rd_chk("memctl rst", oce_pkg::IDX_MEMCTL, 32'h0);
        do_reset(8'h10, 2'h0);
        wr(oce_pkg::IDX_MEMCTL, 32'h80);
        rd_chk("memctl forced", oce_pkg::IDX_MEMCTL, 32'h0);
        check("wor opt off", 32'(wired_or_irq), 32'h0);
    endtask

    // ----------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------
    initial
    begin
        t_regs();
        t_ratio();
        t_boot();
        t_wdog();
        t_pull();
        t_wor();
        report_and_stop();
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
